// >>> verif/nipm_src_model.sv
`timescale 1ns/1ps
module nipm_src_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [13:0] set_p,
  input  wire logic        clr,
  input  wire logic        take,
  input  wire logic [3:0]  idx,
  output logic      [13:0] pend
);
  // Requests stay latched until their routine is entered or software clears them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend <= 14'h0;
    else
      pend <= (pend | set_p) & ~({14{clr}} | (take ? 14'h1 << idx : 14'h0));
  end
endmodule : nipm_src_model

// >>> verif/test_nested_irq_priority_map.sv
`timescale 1ns/1ps
module test_nested_irq_priority_map;
  logic        MCLK = 1'b0, RST_B = 1'b0, rd = 1'b0, wr = 1'b0, clr = 1'b0;
  logic        top_en = 1'b0, bnd = 1'b0, rst_ent = 1'b0, spi = 1'b0, art = 1'b0;
  logic        ahalt = 1'b0, wait_r, take, jm, jn, wake;
  logic [3:0]  addr = 4'h0, be = 4'h0, idx;
  logic [31:0] wd = 32'h0, rdata, got;
  logic [13:0] setp = 14'h0, pend, pm;
  logic [15:0] vaddr;
  logic [1:0]  lvl, cur, pl;
  logic [1:0]  prio [14];
  int          errors = 0, n_compared = 0;
  nipm_pkg::nipm_instr_t ins = '0;

  nipm_top uut (.MCLK(MCLK), .RST_B(RST_B), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_r), .IRQ_PEND(pend), .TOP_LEVEL_PIN_IRQ(top_en),
    .INSTR_BOUNDARY(bnd), .RESET_ENTRY(rst_ent), .INSTR(ins), .SPI_SLAVE_MODE(spi),
    .ART_EXT_CLOCK(art), .ACTIVE_HALT(ahalt), .IRQ_TAKE(take), .IRQ_INDEX(idx),
    .IRQ_VECTOR_ADDR(vaddr), .CURRENT_LEVEL(lvl), .JUMP_IF_MASKED(jm),
    .JUMP_IF_UNMASKED(jn), .HALT_WAKE(wake));
  nipm_src_model src (.clk(MCLK), .rst_n(RST_B), .set_p(setp), .clr(clr), .take(take),
    .idx(idx), .pend(pend));

  always #12.5 MCLK = ~MCLK;

  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      errors++;
    end
  endtask : chk

  // Numeric rank of an encoded level
  function automatic int rk(input logic [1:0] e);
    return (e == 2'h2) ? 0 : (e == 2'h1) ? 1 : (e == 2'h0) ? 2 : 3;
  endfunction : rk

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    addr <= a;
    wd <= {24'h0, d};
    be <= b;
    rd <= ~w;
    wr <= w;
    do
      @(posedge MCLK);
    while (wait_r !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge MCLK);
  endtask : bus

  function automatic logic [7:0] regv(input int r);
    logic [7:0] v;
    for (int p = 0; p < 4; p++)
      v[2*p+:2] = (4 * r + p < 14) ? prio[4*r+p] : 2'h3;
    return v;
  endfunction : regv

  task automatic wreg(input int r, input logic [7:0] d);
    bus(1'b1, 4'(4 * r), d, 4'hf);
    for (int p = 0; p < 4; p++)
      if (d[2*p+:2] != 2'h2 && 4 * r + p < 14)
        prio[4*r+p] = d[2*p+:2];
  endtask : wreg

  task automatic rreg(input int r);
    bus(1'b0, 4'(4 * r), 8'h00, 4'hf);
    chk("priority register", {24'h0, regv(r)}, got);
  endtask : rreg

  task automatic pulse_ins(input logic [8:0] v);
    ins <= nipm_pkg::nipm_instr_t'(v);
    @(posedge MCLK);
    ins <= '0;
    repeat (3) @(posedge MCLK);
  endtask : pulse_ins

  task automatic raise(input logic [13:0] p, input logic c);
    setp <= p;
    clr <= c;
    pm = c ? 14'h0 : pm | p;
    @(posedge MCLK);
    setp <= 14'h0;
    clr <= 1'b0;
    @(posedge MCLK);
  endtask : raise

  task automatic arb();
    int b;
    b = -1;
    if (pm[0] && top_en)
      b = 0;
    else
      for (int v = 13; v > 0; v--)
        if (pm[v] && rk(prio[v]) > rk(cur) && (b < 0 || rk(prio[v]) >= rk(prio[b])))
          b = v;
    bnd <= 1'b1;
    @(posedge MCLK);
    bnd <= 1'b0;
    // Take stands for one cycle only
    @(posedge MCLK);
    chk("take", 32'(b >= 0), 32'(take));
    if (b >= 0)
    begin
      cur = (b == 0) ? 2'h3 : prio[b];
      pm[b] = 1'b0;
      chk("index", 32'(b), 32'(idx));
      chk("vector address", 32'hfffa - 32'(2 * b), 32'(vaddr));
    end
    chk("level", 32'(cur), 32'(lvl));
    @(posedge MCLK);
  endtask : arb

  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'hdd5f78c4));
    for (int v = 0; v < 14; v++)
      prio[v] = 2'h3;
    pm = 14'h0;
    repeat (10) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge MCLK);
    chk("level", 32'h3, 32'(lvl));
    chk("jump masked", 32'h1, 32'(jm));
    chk("vector address", 32'hfffe, 32'(vaddr));
    for (int r = 0; r < 4; r++)
      rreg(r);
    wreg(0, 8'hcf);
    wreg(0, 8'h64);
    rreg(0);
    for (int i = 0; i < 12; i++)
    begin
      wreg(i % 4, 8'($urandom));
      rreg(i % 4);
    end
    bus(1'b1, 4'h4, 8'h00, 4'he);
    rreg(1);
    bus(1'b0, 4'h2, 8'h00, 4'hf);
    chk("unaligned read", 32'h0, got);
    for (int k = 0; k < 7; k++)
    begin
      pl = 2'($urandom);
      pulse_ins({7'h40 >> k, pl});
      cur = (k == 0 || k == 3 || k == 4) ? 2'h2 : (k < 3) ? 2'h3 : pl;
      chk("level", 32'(cur), 32'(lvl));
      if (k == 2)
        chk("vector address", 32'hfffc, 32'(vaddr));
      chk("jump masked", 32'(cur == 2'h3), 32'(jm));
      chk("jump unmasked", 32'(cur != 2'h3), 32'(jn));
    end
    for (int n = 0; n < 10; n++)
    begin
      for (int r = 0; r < 4; r++)
        wreg(r, 8'($urandom));
      pulse_ins(9'h100);
      cur = 2'h2;
      top_en <= 1'($urandom);
      raise(14'($urandom), 1'b0);
      repeat (3) arb();
      raise(14'h0, 1'b1);
    end
    pulse_ins(9'h100);
    for (int v = 1; v < 14; v++)
    begin
      {spi, art, ahalt} <= 3'($urandom);
      raise(14'h1 << v, 1'b0);
      repeat (2) @(posedge MCLK);
      chk("wake", 32'(ahalt ? v == 1 : v < 7 || (v == 7 && spi) || (v == 13 && art)),
          32'(wake));
      raise(14'h0, 1'b1);
    end
    rst_ent <= 1'b1;
    @(posedge MCLK);
    rst_ent <= 1'b0;
    repeat (3) @(posedge MCLK);
    chk("level", 32'h3, 32'(lvl));
    end_of_test();
  end
endmodule : test_nested_irq_priority_map

// >>> verilog/nipm_pkg.sv
package nipm_pkg;
  localparam int unsigned NUM_VEC       = 14;
  localparam int unsigned NUM_PRIO_REGS = 4;
  localparam int unsigned ADDR_W        = 4;
  // Byte addresses of the registers on the Avalon-MM slave
  localparam logic [3:0]  OFS_PRIO0     = 4'h0;
  localparam logic [3:0]  OFS_PRIO1     = 4'h4;
  localparam logic [3:0]  OFS_PRIO2     = 4'h8;
  localparam logic [3:0]  OFS_PRIO3     = 4'hc;
  localparam logic [7:0]  PRIO_RESET    = 8'hff;
  localparam logic [7:0]  PRIO3_RO_MASK = 8'hf0;
  // Current-level encodings
  localparam logic [1:0]  LVL0          = 2'h2;
  localparam logic [1:0]  LVL1          = 2'h1;
  localparam logic [1:0]  LVL2          = 2'h0;
  localparam logic [1:0]  LVL3          = 2'h3;
  localparam logic [3:0]  VEC_TOP_PIN   = 4'h0;
  localparam logic [3:0]  VEC_TIMEBASE  = 4'h1;
  localparam logic [3:0]  VEC_SPI       = 4'h7;
  localparam logic [3:0]  VEC_ART       = 4'hd;
  // Vector slots: base FFE0, slot of vector x is FFFA - 2x
  localparam logic [15:0] VADDR_RESET   = 16'hfffe;
  localparam logic [15:0] VADDR_TRAP    = 16'hfffc;
  localparam logic [15:0] VADDR_TOP     = 16'hfffa;
  // Vectors that can wake from halt unconditionally outside active halt on flash parts (bit per vector)
  localparam logic [13:0] HALT_WAKE_MASK = 14'h007f;
  localparam logic [13:0] ACTIVE_HALT_WAKE_MASK = 14'h0002;
  localparam int unsigned RDATA_W       = 32;

  typedef enum logic [3:0]
  {
    ST_RUN   = 4'h1,
    ST_ENTRY = 4'h2,
    ST_NMI   = 4'h4,
    ST_HOLD  = 4'h8
  } nipm_state_t;

  // Level-changing instruction strobes from the core
  typedef struct packed
  {
    logic enable_instr;
    logic disable_instr;
    logic trap_instr;
    logic wait_instr;
    logic halt_instr;
    logic flags_pop;
    logic irq_return;
    logic [1:0] pop_level;
  } nipm_instr_t;
endpackage : nipm_pkg

// >>> verilog/nipm_top.sv
`timescale 1ns/1ps
module nipm_top #(
  parameter int unsigned NV       = nipm_pkg::NUM_VEC,
  parameter bit          IS_FLASH = 1'b1
) (
  input  wire logic                          MCLK,
  input  wire logic                          RST_B,
  input  wire logic [nipm_pkg::ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                          AVS_READ,
  input  wire logic                          AVS_WRITE,
  input  wire logic [31:0]                   AVS_WRITEDATA,
  input  wire logic [3:0]                    AVS_BYTEENABLE,
  output logic [31:0]                        AVS_READDATA,
  output logic                               AVS_WAITREQUEST,
  input  wire logic [NV-1:0]                 IRQ_PEND,
  input  wire logic                          TOP_LEVEL_PIN_IRQ,
  input  wire logic                          INSTR_BOUNDARY,
  input  wire logic                          RESET_ENTRY,
  input  wire nipm_pkg::nipm_instr_t         INSTR,
  input  wire logic                          SPI_SLAVE_MODE,
  input  wire logic                          ART_EXT_CLOCK,
  input  wire logic                          ACTIVE_HALT,
  output logic                               IRQ_TAKE,
  output logic [3:0]                         IRQ_INDEX,
  output logic [15:0]                        IRQ_VECTOR_ADDR,
  output logic [1:0]                         CURRENT_LEVEL,
  output logic                               JUMP_IF_MASKED,
  output logic                               JUMP_IF_UNMASKED,
  output logic                               HALT_WAKE
);

  // Rank of a level: 0 main .. 3 masked
  function automatic logic [1:0] lvl_rank(input logic [1:0] enc);
    case (enc)
      nipm_pkg::LVL0: lvl_rank = 2'h0;
      nipm_pkg::LVL1: lvl_rank = 2'h1;
      nipm_pkg::LVL2: lvl_rank = 2'h2;
      default:        lvl_rank = 2'h3;
    endcase
  endfunction : lvl_rank

  // Merge a written pair, dropping the level-zero pattern
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v);
    logic [7:0] r;
    r = new_v;
    for (int p = 0; p < 4; p++)
    begin
      if (new_v[2*p +: 2] == nipm_pkg::LVL0)
        r[2*p +: 2] = old_v[2*p +: 2];
    end
    merge_byte = r;
  endfunction : merge_byte

  logic [7:0]             prio_q [nipm_pkg::NUM_PRIO_REGS];
  logic [1:0]             cur_q;
  logic [1:0]             cur_d;
  logic                   ack_q;
  logic                   ack_d;
  nipm_pkg::nipm_state_t  state_q;
  logic [1:0]             reg_idx;
  logic                   wr_hit;
  logic                   rd_hit;
  logic [2*NV-1:0]        pairs;

  assign reg_idx = AVS_ADDRESS[3:2];
  // A write lands on the edge at which the master sees waitrequest low
  assign wr_hit  = AVS_WRITE && ack_q && AVS_BYTEENABLE[0] && (AVS_ADDRESS[1:0] == 2'h0);
  assign rd_hit  = AVS_READ && !ack_q;

  // One wait state: waitrequest drops in the cycle after the request rises
  always_comb
  begin
    ack_d = (AVS_READ || AVS_WRITE) && !ack_q;
  end

  // Waitrequest comes from its own flip-flop, not through an inverter
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ack_q           <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
    end
    else
    begin
      ack_q           <= ack_d;
      AVS_WAITREQUEST <= !ack_d;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      for (int i = 0; i < nipm_pkg::NUM_PRIO_REGS; i++)
        prio_q[i] <= nipm_pkg::PRIO_RESET;
    else if (wr_hit)
    begin
      prio_q[reg_idx] <= merge_byte(prio_q[reg_idx], AVS_WRITEDATA[7:0]);
      if (AVS_ADDRESS == nipm_pkg::OFS_PRIO3)
        prio_q[3] <= merge_byte(prio_q[3], AVS_WRITEDATA[7:0]) | nipm_pkg::PRIO3_RO_MASK;
    end
  end

  // Read data registered on the edge that drops waitrequest, one edge before the acknowledging edge
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      AVS_READDATA <= 32'h0000_0000;
    else if (rd_hit)
    begin
      if (AVS_ADDRESS[1:0] == 2'h0)
        AVS_READDATA <= {24'h00_0000, prio_q[reg_idx]};
      else
        AVS_READDATA <= 32'h0000_0000;
    end
  end

  // Pair x belongs to vector x
  always_comb
  begin
    pairs = '0;
    for (int v = 0; v < NV; v++)
      pairs[2*v +: 2] = prio_q[v/4][2*(v%4) +: 2];
  end

  // Arbitration, top pin slot excluded
  logic [3:0] best_idx;
  logic [1:0] best_rank;
  logic       best_ok;
  always_comb
  begin
    best_idx  = '0;
    best_rank = '0;
    best_ok   = 1'b0;
    // Walking downwards lets the lower vector win a tie
    for (int v = NV-1; v >= 1; v--)
    begin
      if (IRQ_PEND[v] && lvl_rank(pairs[2*v +: 2]) > lvl_rank(cur_q) &&
          (!best_ok || lvl_rank(pairs[2*v +: 2]) >= best_rank))
      begin
        best_ok   = 1'b1;
        best_rank = lvl_rank(pairs[2*v +: 2]);
        best_idx  = v[3:0];
      end
    end
  end

  logic top_go;
  assign top_go = TOP_LEVEL_PIN_IRQ && IRQ_PEND[0];

  // An entry is taken only at an instruction boundary
  logic take_d;
  assign take_d = INSTR_BOUNDARY && (top_go || best_ok);

  // Entry / level updates
  always_comb
  begin
    // Later lines win: instructions, then entry, then reset entry
    cur_d = cur_q;
    if (INSTR.irq_return || INSTR.flags_pop)
      cur_d = INSTR.pop_level;
    if (INSTR.enable_instr || INSTR.wait_instr || INSTR.halt_instr)
      cur_d = nipm_pkg::LVL0;
    if (INSTR.disable_instr || INSTR.trap_instr)
      cur_d = nipm_pkg::LVL3;
    if (INSTR_BOUNDARY && top_go)
      cur_d = nipm_pkg::LVL3;
    else if (INSTR_BOUNDARY && best_ok)
      cur_d = pairs[2*best_idx +: 2];
    if (RESET_ENTRY)
      cur_d = nipm_pkg::LVL3;
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      cur_q <= nipm_pkg::LVL3;
    else
      cur_q <= cur_d;
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      state_q <= nipm_pkg::ST_RUN;
    else
      case (state_q)
        nipm_pkg::ST_RUN:   state_q <= take_d ? nipm_pkg::ST_ENTRY : nipm_pkg::ST_RUN;
        nipm_pkg::ST_ENTRY: state_q <= take_d ? nipm_pkg::ST_ENTRY : nipm_pkg::ST_RUN;
        default:            state_q <= nipm_pkg::ST_RUN;
      endcase
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      IRQ_TAKE        <= 1'b0;
      IRQ_INDEX       <= 4'h0;
      IRQ_VECTOR_ADDR <= nipm_pkg::VADDR_RESET;
    end
    else
    begin
      IRQ_TAKE <= take_d;
      if (INSTR_BOUNDARY && top_go)
      begin
        IRQ_INDEX       <= nipm_pkg::VEC_TOP_PIN;
        IRQ_VECTOR_ADDR <= nipm_pkg::VADDR_TOP;
      end
      else if (INSTR_BOUNDARY && best_ok)
      begin
        IRQ_INDEX       <= best_idx;
        IRQ_VECTOR_ADDR <= nipm_pkg::VADDR_TOP - {11'h000, best_idx, 1'b0};
      end
      else if (INSTR.trap_instr)
        IRQ_VECTOR_ADDR <= nipm_pkg::VADDR_TRAP;
    end
  end

  // Wake qualification
  logic [NV-1:0] wake_ok;
  always_comb
  begin
    wake_ok = nipm_pkg::HALT_WAKE_MASK[NV-1:0];
    wake_ok[nipm_pkg::VEC_SPI] = SPI_SLAVE_MODE;
    wake_ok[nipm_pkg::VEC_ART] = ART_EXT_CLOCK;
    if (ACTIVE_HALT && IS_FLASH)
      wake_ok = nipm_pkg::ACTIVE_HALT_WAKE_MASK[NV-1:0];
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      HALT_WAKE        <= 1'b0;
      CURRENT_LEVEL    <= nipm_pkg::LVL3;
      JUMP_IF_MASKED   <= 1'b1;
      JUMP_IF_UNMASKED <= 1'b0;
    end
    else
    begin
      HALT_WAKE        <= |(IRQ_PEND & wake_ok) || RESET_ENTRY;
      CURRENT_LEVEL    <= cur_d;
      JUMP_IF_MASKED   <= (cur_d == nipm_pkg::LVL3);
      JUMP_IF_UNMASKED <= (cur_d != nipm_pkg::LVL3);
    end
  end

  // Assertion helpers: what a write, an entry or a level pop saw one cycle earlier
  logic [1:0] chk_idx_q;
  logic [1:0] chk_old_q;
  logic [1:0] chk_wd_q;
  logic [1:0] chk_sel_q;
  logic [1:0] chk_pop_q;
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      chk_idx_q <= 2'h0;
      chk_old_q <= 2'h0;
      chk_wd_q  <= 2'h0;
      chk_sel_q <= 2'h0;
      chk_pop_q <= 2'h0;
    end
    else
    begin
      chk_idx_q <= reg_idx;
      chk_old_q <= prio_q[reg_idx][1:0];
      chk_wd_q  <= AVS_WRITEDATA[1:0];
      chk_sel_q <= pairs[2*best_idx +: 2];
      chk_pop_q <= INSTR.pop_level;
    end
  end

  chk_prio3_ro: assert property (@(posedge MCLK) disable iff (!RST_B)
    (prio_q[3] & nipm_pkg::PRIO3_RO_MASK) == nipm_pkg::PRIO3_RO_MASK)
    else $error("upper nibble of register 3 lost");
  chk_lvl0_ignored: assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_hit && AVS_WRITEDATA[1:0] == nipm_pkg::LVL0 |=> prio_q[chk_idx_q][1:0] == chk_old_q)
    else $error("level zero pattern stored");
  chk_enable_level: assert property (@(posedge MCLK) disable iff (!RST_B)
    INSTR.enable_instr && !INSTR.disable_instr && !INSTR.trap_instr && !INSTR_BOUNDARY
    && !RESET_ENTRY |=> cur_q == nipm_pkg::LVL0)
    else $error("enable did not set level 0");
  chk_disable_level: assert property (@(posedge MCLK) disable iff (!RST_B)
    INSTR.disable_instr && !INSTR_BOUNDARY |=> cur_q == nipm_pkg::LVL3)
    else $error("disable did not set level 3");
  chk_top_level3: assert property (@(posedge MCLK) disable iff (!RST_B)
    INSTR_BOUNDARY && top_go |=> cur_q == nipm_pkg::LVL3 && IRQ_TAKE && IRQ_INDEX == 4'h0)
    else $error("top pin entry wrong");
  chk_served_above: assert property (@(posedge MCLK) disable iff (!RST_B)
    INSTR_BOUNDARY && best_ok |-> lvl_rank(pairs[2*best_idx +: 2]) > lvl_rank(cur_q))
    else $error("served at or below current level");
  chk_jump_flags: assert property (@(posedge MCLK) disable iff (!RST_B)
    JUMP_IF_MASKED == (CURRENT_LEVEL == nipm_pkg::LVL3) && JUMP_IF_MASKED != JUMP_IF_UNMASKED)
    else $error("jump conditions inconsistent");
  chk_entry_level: assert property (@(posedge MCLK) disable iff (!RST_B)
    INSTR_BOUNDARY && best_ok && !top_go && !RESET_ENTRY |=> cur_q == chk_sel_q)
    else $error("entry level not loaded");
  chk_vector_addr: assert property (@(posedge MCLK) disable iff (!RST_B)
    IRQ_TAKE |-> IRQ_VECTOR_ADDR == nipm_pkg::VADDR_TOP - {11'h000, IRQ_INDEX, 1'b0})
    else $error("vector slot mismatch");
  // Register bus
  chk_write_lands: assert property (@(posedge MCLK) disable iff (!RST_B)
    wr_hit && AVS_WRITEDATA[1:0] != nipm_pkg::LVL0 |=> prio_q[chk_idx_q][1:0] == chk_wd_q)
    else $error("priority write did not land");
  chk_wait_one: assert property (@(posedge MCLK) disable iff (!RST_B)
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  chk_rdata_upper: assert property (@(posedge MCLK) disable iff (!RST_B)
    AVS_READDATA[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  // Level, entry and halt wake
  chk_take_state: assert property (@(posedge MCLK) disable iff (!RST_B)
    IRQ_TAKE == (state_q == nipm_pkg::ST_ENTRY))
    else $error("take pulse and entry state disagree");
  chk_masked_none: assert property (@(posedge MCLK) disable iff (!RST_B)
    cur_q == nipm_pkg::LVL3 |-> !best_ok)
    else $error("maskable vector selected at level 3");
  chk_reset_entry: assert property (@(posedge MCLK) disable iff (!RST_B)
    RESET_ENTRY |=> cur_q == nipm_pkg::LVL3)
    else $error("reset entry did not set level 3");
  chk_trap_addr: assert property (@(posedge MCLK) disable iff (!RST_B)
    INSTR.trap_instr && !INSTR_BOUNDARY |=> IRQ_VECTOR_ADDR == nipm_pkg::VADDR_TRAP)
    else $error("trap vector address wrong");
  chk_wait_level: assert property (@(posedge MCLK) disable iff (!RST_B)
    (INSTR.wait_instr || INSTR.halt_instr) && !INSTR.disable_instr && !INSTR.trap_instr
    && !INSTR_BOUNDARY && !RESET_ENTRY |=> cur_q == nipm_pkg::LVL0)
    else $error("wait or halt did not set level 0");
  chk_pop_level: assert property (@(posedge MCLK) disable iff (!RST_B)
    (INSTR.irq_return || INSTR.flags_pop) && !INSTR.enable_instr && !INSTR.wait_instr
    && !INSTR.halt_instr && !INSTR.disable_instr && !INSTR.trap_instr && !INSTR_BOUNDARY
    && !RESET_ENTRY |=> cur_q == chk_pop_q)
    else $error("popped level not loaded");
  chk_level_out: assert property (@(posedge MCLK) disable iff (!RST_B)
    CURRENT_LEVEL == cur_q)
    else $error("current level output differs from state");
  chk_flash_halt: assert property (@(posedge MCLK) disable iff (!RST_B)
    ACTIVE_HALT && IS_FLASH && !RESET_ENTRY && !IRQ_PEND[nipm_pkg::VEC_TIMEBASE]
    |=> !HALT_WAKE)
    else $error("wake from timed halt by a wrong vector");
  chk_spi_wake: assert property (@(posedge MCLK) disable iff (!RST_B)
    !SPI_SLAVE_MODE && !RESET_ENTRY && $onehot(IRQ_PEND) && IRQ_PEND[nipm_pkg::VEC_SPI]
    |=> !HALT_WAKE)
    else $error("serial peripheral woke while master");
  chk_art_wake: assert property (@(posedge MCLK) disable iff (!RST_B)
    !ART_EXT_CLOCK && !RESET_ENTRY && $onehot(IRQ_PEND) && IRQ_PEND[nipm_pkg::VEC_ART]
    |=> !HALT_WAKE)
    else $error("auto-reload timer woke on internal clock");

  cov_nested: cover property (@(posedge MCLK) IRQ_TAKE ##[1:20] IRQ_TAKE);
  cov_prio_write: cover property (@(posedge MCLK) wr_hit ##1 IRQ_TAKE);
  cov_wake: cover property (@(posedge MCLK) HALT_WAKE && ACTIVE_HALT);
  cov_top_entry: cover property (@(posedge MCLK) INSTR_BOUNDARY && top_go);
  cov_trap: cover property (@(posedge MCLK) INSTR.trap_instr);
endmodule : nipm_top
